// ===== hw/led_fail_ind.sv
/*
  Two-port LED and link-drop indicator with an APB register slave.
  Assumes port status comes from port logic on clk; low_power_hold is a pin.
*/
`timescale 1ns/1ps
// What this block does
// - Extended first-pin modes: four-bit enable field (any nonzero value) plus selector
// - Mode 20 forces off, 21 on without dimming
// - Mode 22 shows link drop on pin
// - Global bit exchanges the two ports' LEDs
// - Serial LED bits never swapped
// - Combine: primary lit, activity blinks or stretches
// - No combine: primary only, activity ignored except in the activity and collision modes
// - Blink is 50 percent toggle
// - Stretch holds each level a full period
// - Rate picks 2.5, 5, 10, 20 Hz
// - Rate picks 50, 100, 200, 400 ms
// - Only port 0 rate used everywhere
// - Dimming: 5 kHz, 20 percent on
// - Optional one-second blink after wake or soft reset
// - Drop reported within 3 ms
// - Per-port link drop alert pin
// - Interrupt only at 1000 and 100
// - Non-gigabit: indication equals link status
// - Gigabit: integrity monitor drives indication at once
// - Interrupt holds until status cleared
// - LEDs active low
// - Forced modes skip after-reset blink
module led_fail_ind
  import led_fail_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int PWM_CYC = PWM_CYCLES,
  parameter int PWM_ON_CYC = PWM_ON_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port state
  input wire port_stat_t [NPORT-1:0] port_stat,
  input wire logic low_power_hold,
  // Indicators
  output logic [NLED-1:0] led_n,
  output logic [NLED-1:0] serial_led_bits,
  output logic [NPORT-1:0] link_drop_alert_pin,
  output logic management_interrupt_pin_n
);

  // Register file
  logic [3:0] glob_r, glob_nxt;
  port_cfg_t [NPORT-1:0] cfg_r, cfg_nxt;
  logic [NPORT-1:0] irq_r, irq_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, wr_en, hit;
  logic soft_rst;

  always_comb begin
    glob_nxt = glob_r;
    glob_nxt[SOFT_RST_BIT] = 1'b0;
    cfg_nxt = cfg_r;
    wr_en = psel & penable & pready & pwrite;
    pready_nxt = psel & ~penable;
    hit = 1'b1;
    prdata_nxt = 32'h0000_0000;
    case (paddr)
      GLOBAL_OFS: prdata_nxt = {28'h0000000, 1'b0, glob_r[2:0]};
      PORT0_CFG_OFS: prdata_nxt = {14'h0000, cfg_r[0]};
      PORT1_CFG_OFS: prdata_nxt = {14'h0000, cfg_r[1]};
      PORT0_IRQ_OFS: prdata_nxt = 32'(irq_r[0]) << DROP_IRQ_BIT | 32'(port_stat[0].link_up) << LINK_STAT_BIT;
      PORT1_IRQ_OFS: prdata_nxt = 32'(irq_r[1]) << DROP_IRQ_BIT | 32'(port_stat[1].link_up) << LINK_STAT_BIT;
      default: hit = 1'b0;
    endcase
    pslverr_nxt = pready_nxt & ~hit;
    if (wr_en && paddr == GLOBAL_OFS) begin
      glob_nxt = pwdata[3:0];
    end
    if (wr_en && paddr == PORT0_CFG_OFS) begin
      cfg_nxt[0] = pwdata[CFG_W-1:0];
    end
    if (wr_en && paddr == PORT1_CFG_OFS) begin
      cfg_nxt[1] = pwdata[CFG_W-1:0];
    end
  end

  assign soft_rst = glob_r[SOFT_RST_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      glob_r <= GLOBAL_RESET;
      cfg_r <= {NPORT{CFG_RESET[CFG_W-1:0]}};
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      glob_r <= glob_nxt;
      cfg_r <= cfg_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // Link drop indication, high while the link is good
  logic [NPORT-1:0] good, good_r, drop_ev, clr;

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      if (port_stat[p].speed == SPD_1000) begin
        good[p] = port_stat[p].link_up & ~port_stat[p].integrity_fail;
      end else begin
        good[p] = port_stat[p].link_up;
      end
      drop_ev[p] = good_r[p] & ~good[p] & (port_stat[p].speed != SPD_10);
      clr[p] = wr_en & pwdata[DROP_IRQ_BIT] & (paddr == (p == 0 ? PORT0_IRQ_OFS : PORT1_IRQ_OFS));
      // A drop in the clearing cycle stays pending
      irq_nxt[p] = drop_ev[p] | (irq_r[p] & ~clr[p]);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      good_r <= '0;
      irq_r <= '0;
      link_drop_alert_pin <= '0;
      management_interrupt_pin_n <= 1'b1;
    end else begin
      good_r <= good;
      irq_r <= irq_nxt;
      // One cycle from status to pin, far inside the 3 ms bound
      link_drop_alert_pin <= good;
      management_interrupt_pin_n <= ~|irq_nxt;
    end
  end

  // Wake pin synchroniser
  logic hold_s1_r, hold_s2_r, hold_d_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_s1_r <= 1'b0;
      hold_s2_r <= 1'b0;
      hold_d_r <= 1'b0;
    end else begin
      hold_s1_r <= low_power_hold;
      hold_s2_r <= hold_s1_r;
      hold_d_r <= hold_s2_r;
    end
  end

  // Timebase; soft reset restarts it as well
  logic [31:0] tick_div_r, tick_div_nxt, pwm_div_r, pwm_div_nxt;
  logic [4:0] tick_cnt_r, tick_cnt_nxt, stretch_ticks;
  logic tick, blink_phase, pwm_on;
  logic [1:0] rate;

  always_comb begin
    rate = cfg_r[0].rate;
    tick = tick_div_r == 32'(TICK_CYC - 1);
    tick_div_nxt = tick ? 32'h0000_0000 : tick_div_r + 32'h0000_0001;
    tick_cnt_nxt = tick ? tick_cnt_r + 5'h01 : tick_cnt_r;
    pwm_div_nxt = (pwm_div_r == 32'(PWM_CYC - 1)) ? 32'h0000_0000 : pwm_div_r + 32'h0000_0001;
    pwm_on = pwm_div_r < 32'(PWM_ON_CYC);
    if (soft_rst) begin
      tick_div_nxt = 32'h0000_0000;
      tick_cnt_nxt = 5'h00;
      pwm_div_nxt = 32'h0000_0000;
    end
    // Half period 200, 100, 50, 25 ms
    case (rate)
      2'h0: blink_phase = tick_cnt_r[3];
      2'h1: blink_phase = tick_cnt_r[2];
      2'h2: blink_phase = tick_cnt_r[1];
      default: blink_phase = tick_cnt_r[0];
    endcase
    stretch_ticks = STRETCH_BASE_TICKS << rate;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_div_r <= 32'h0000_0000;
      tick_cnt_r <= 5'h00;
      pwm_div_r <= 32'h0000_0000;
    end else begin
      tick_div_r <= tick_div_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      pwm_div_r <= pwm_div_nxt;
    end
  end

  // One-second blink after wake or soft reset
  after_rst_t ar_r, ar_nxt;
  logic [5:0] ar_cnt_r, ar_cnt_nxt;
  logic ar_start;

  always_comb begin
    ar_start = glob_r[AFTER_RST_EN_BIT] & (soft_rst | (hold_d_r & ~hold_s2_r));
    ar_nxt = ar_r;
    ar_cnt_nxt = ar_cnt_r;
    case (ar_r)
      AR_IDLE: begin
        if (ar_start) begin
          ar_nxt = AR_RUN;
          ar_cnt_nxt = 6'h00;
        end
      end
      AR_RUN: begin
        if (tick) begin
          ar_cnt_nxt = ar_cnt_r + 6'h01;
        end
        if (tick && ar_cnt_r == ONE_SEC_TICKS - 6'h01) begin
          ar_nxt = AR_IDLE;
        end
      end
      default: ar_nxt = AR_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ar_r <= AR_IDLE;
      ar_cnt_r <= 6'h00;
    end else begin
      ar_r <= ar_nxt;
      ar_cnt_r <= ar_cnt_nxt;
    end
  end

  // Per pin: decode mode, drive, then swap
  logic [NLED-1:0] pin_n, ser_nxt;

  for (genvar i = 0; i < NLED; i++) begin : g_pin
    localparam int P = i / NPIN;
    localparam int J = i % NPIN;
    logic [4:0] mode;
    logic prim, sec, sec_only, forced, no_pulse, lk, g1000, g100, g10;

    always_comb begin
      lk = port_stat[P].link_up;
      g1000 = lk & (port_stat[P].speed == SPD_1000);
      g100 = lk & (port_stat[P].speed == SPD_100);
      g10 = lk & (port_stat[P].speed == SPD_10);
      mode = {1'b0, (J == 0) ? cfg_r[P].mode0 : cfg_r[P].mode1};
      if (J == 0 && cfg_r[P].ext_en != 4'h0) begin
        mode = M_EXT_BASE | mode;
      end
      prim = 1'b0;
      sec = lk & port_stat[P].activity;
      sec_only = 1'b0;
      forced = 1'b0;
      no_pulse = 1'b0;
      case (mode)
        M_LINK_ACT: prim = lk;
        M_L1000: prim = g1000;
        M_L100: prim = g100;
        M_L10: prim = g10;
        M_L100_1000: prim = g100 | g1000;
        M_L10_1000: prim = g10 | g1000;
        M_L10_100: prim = g10 | g100;
        M_DUP_COL: begin
          prim = lk & port_stat[P].full_duplex;
          sec = lk & ~port_stat[P].full_duplex & port_stat[P].collision;
        end
        M_COL: begin
          sec = port_stat[P].collision;
          sec_only = 1'b1;
        end
        M_ACT: sec_only = 1'b1;
        M_ANEG_FAULT: prim = port_stat[P].an_fault;
        M_FORCE_OFF, M_X_OFF: begin
          sec = 1'b0;
          forced = 1'b1;
        end
        M_FORCE_ON: begin
          prim = 1'b1;
          sec = 1'b0;
          forced = 1'b1;
        end
        M_X_ON: begin
          prim = 1'b1;
          sec = 1'b0;
          forced = 1'b1;
          no_pulse = 1'b1;
        end
        M_X_DROP: begin
          prim = ~good_r[P];
          sec = 1'b0;
        end
        default: sec = 1'b0;
      endcase
    end

    led_pin_drive u_drive (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .blink_phase(blink_phase),
      .pwm_on(pwm_on),
      .stretch_ticks(stretch_ticks),
      .stretch_sel(cfg_r[P].stretch[J]),
      .combine(cfg_r[P].combine[J]),
      .pulse_en(glob_r[PULSE_EN_BIT]),
      .after_rst(ar_r == AR_RUN),
      .primary(prim),
      .secondary(sec),
      .sec_only(sec_only),
      .forced(forced),
      .no_pulse(no_pulse),
      .led_n_r(pin_n[i])
    );
  end

  always_comb begin
    ser_nxt = ~pin_n;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_n <= '1;
      serial_led_bits <= '0;
    end else begin
      led_n <= glob_r[SWAP_BIT] ? {pin_n[NPIN-1:0], pin_n[NLED-1:NPIN]} : pin_n;
      serial_led_bits <= ser_nxt;
    end
  end

endmodule // led_fail_ind

// ===== hw/led_fail_pkg.sv
/*
  Shared constants and types for the two-port LED and link-drop indicator:
  register map, field layout, LED mode codes and timing counts.
  Assumes a 200 MHz core clock.
*/
package led_fail_pkg;

  localparam int NPORT = 2;
  localparam int NPIN = 2;
  localparam int NLED = NPORT * NPIN;

  // Register byte offsets
  localparam logic [7:0] GLOBAL_OFS = 8'h00;
  localparam logic [7:0] PORT0_CFG_OFS = 8'h04;
  localparam logic [7:0] PORT1_CFG_OFS = 8'h08;
  localparam logic [7:0] PORT0_IRQ_OFS = 8'h0C;
  localparam logic [7:0] PORT1_IRQ_OFS = 8'h10;

  // Global register fields
  localparam int SWAP_BIT = 0;
  localparam int PULSE_EN_BIT = 1;
  localparam int AFTER_RST_EN_BIT = 2;
  localparam int SOFT_RST_BIT = 3;
  // Interrupt status fields
  localparam int DROP_IRQ_BIT = 7;
  localparam int LINK_STAT_BIT = 2;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [3:0] GLOBAL_RESET = 4'h0;

  // Port configuration word, low 18 bits of the register
  typedef struct packed {
    logic [1:0] rate;
    logic [1:0] stretch;
    logic [1:0] combine;
    logic [3:0] ext_en;
    logic [3:0] mode1;
    logic [3:0] mode0;
  } port_cfg_t;
  localparam int CFG_W = 18;

  // Link state from the port core, same clock domain
  typedef struct packed {
    logic link_up;
    logic [1:0] speed;
    logic full_duplex;
    logic activity;
    logic collision;
    logic an_fault;
    logic integrity_fail;
  } port_stat_t;

  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

  // LED mode codes, basic then extended
  localparam logic [4:0] M_LINK_ACT = 5'h00;
  localparam logic [4:0] M_L1000 = 5'h01;
  localparam logic [4:0] M_L100 = 5'h02;
  localparam logic [4:0] M_L10 = 5'h03;
  localparam logic [4:0] M_L100_1000 = 5'h04;
  localparam logic [4:0] M_L10_1000 = 5'h05;
  localparam logic [4:0] M_L10_100 = 5'h06;
  localparam logic [4:0] M_DUP_COL = 5'h08;
  localparam logic [4:0] M_COL = 5'h09;
  localparam logic [4:0] M_ACT = 5'h0A;
  localparam logic [4:0] M_ANEG_FAULT = 5'h0C;
  localparam logic [4:0] M_FORCE_OFF = 5'h0E;
  localparam logic [4:0] M_FORCE_ON = 5'h0F;
  localparam logic [4:0] M_EXT_BASE = 5'h10;
  localparam logic [4:0] M_X_OFF = 5'h14;
  localparam logic [4:0] M_X_ON = 5'h15;
  localparam logic [4:0] M_X_DROP = 5'h16;

  // Timing: a 25 ms tick is the base of blink, stretch and the one-second run
  localparam longint CLK_HZ = 200_000_000;
  localparam longint TICK_US = 25_000;
  localparam int TICK_CYCLES = int'(CLK_HZ / 1_000_000 * TICK_US);
  localparam int PWM_PERIOD_US = 200;
  localparam int PWM_ON_PCT = 20;
  localparam int PWM_CYCLES = int'(CLK_HZ / 1_000_000 * PWM_PERIOD_US);
  localparam int PWM_ON_CYCLES = PWM_CYCLES * PWM_ON_PCT / 100;
  localparam int ONE_SEC_MS = 1000;
  localparam logic [5:0] ONE_SEC_TICKS = 6'(ONE_SEC_MS * 1000 / TICK_US);
  localparam logic [4:0] STRETCH_BASE_TICKS = 5'h02;

  typedef enum logic [1:0] {
    AR_IDLE = 2'b01,
    AR_RUN = 2'b10
  } after_rst_t;

endpackage

// ===== hw/led_pin_drive.sv
/*
  One LED pin: combine, blink or pulse-stretch, after-reset blink, dimming.
  Assumes tick, blink phase and dimming window come from the same clock.
*/
`timescale 1ns/1ps
module led_pin_drive
  import led_fail_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Timing
  input wire logic tick,
  input wire logic blink_phase,
  input wire logic pwm_on,
  input wire logic [4:0] stretch_ticks,
  // Behaviour
  input wire logic stretch_sel,
  input wire logic combine,
  input wire logic pulse_en,
  input wire logic after_rst,
  // Decoded mode
  input wire logic primary,
  input wire logic secondary,
  input wire logic sec_only,
  input wire logic forced,
  input wire logic no_pulse,
  // Pin level, active low
  output logic led_n_r
);

  logic lv_r, lv_nxt, led_n_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic sec_on, busy, on;

  always_comb begin
    sec_on = secondary & (combine | sec_only);
    busy = cnt_r != 5'h00;
    lv_nxt = lv_r;
    cnt_nxt = cnt_r;
    if (tick && busy) begin
      cnt_nxt = cnt_r - 5'h01;
    end else if (!busy) begin
      // Each level held a full period even for short events
      if (sec_on) begin
        lv_nxt = ~lv_r;
        cnt_nxt = stretch_ticks;
      end else begin
        lv_nxt = 1'b0;
      end
    end
    if (after_rst && !forced) begin
      on = blink_phase;
    end else if (stretch_sel && (busy || sec_on)) begin
      on = lv_r;
    end else if (!stretch_sel && sec_on) begin
      on = blink_phase;
    end else begin
      on = primary;
    end
    led_n_nxt = ~(on & (pwm_on | ~pulse_en | no_pulse));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lv_r <= 1'b0;
      cnt_r <= 5'h00;
      led_n_r <= 1'b1;
    end else begin
      lv_r <= lv_nxt;
      cnt_r <= cnt_nxt;
      led_n_r <= led_n_nxt;
    end
  end

endmodule // led_pin_drive

// ===== tb/led_fail_ind_sva.sv
/*
  Port-level checker for led_fail_ind: APB answers and link-drop pins.
  Assumes the bench runs zero-wait APB transfers and changes speed rarely.
*/
`timescale 1ns/1ps
module led_fail_ind_sva
  import led_fail_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status and indicators
  input wire port_stat_t [NPORT-1:0] port_stat,
  input wire logic low_power_hold,
  input wire logic [NLED-1:0] led_n,
  input wire logic [NLED-1:0] serial_led_bits,
  input wire logic [NPORT-1:0] link_drop_alert_pin,
  input wire logic management_interrupt_pin_n
);
  logic mapped;
  always_comb mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_pready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
  a_zero_wait_answer: assert property (psel && !penable |=> pready) else $error("no zero-wait answer");
  a_unmapped_error: assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong");
  a_error_data_zero: assert property (pslverr |-> prdata == 32'h0) else $error("prdata not zero on error");
  a_alert_link_status: assert property (port_stat[0].speed != SPD_1000 |=>
    link_drop_alert_pin[0] == $past(port_stat[0].link_up)) else $error("alert differs from link");
  a_gig_integrity_alert: assert property (port_stat[1].speed == SPD_1000 |=>
    link_drop_alert_pin[1] == ($past(port_stat[1].link_up) && !$past(port_stat[1].integrity_fail)))
    else $error("gigabit alert wrong");
  a_irq_on_drop: assert property ($fell(link_drop_alert_pin[0]) && $past(port_stat[0].speed) != SPD_10
    |-> !management_interrupt_pin_n) else $error("no interrupt on drop");
  a_irq_holds_low: assert property (!management_interrupt_pin_n && !(psel && penable && pwrite && pwdata[7])
    |=> !management_interrupt_pin_n) else $error("interrupt released early");
  a_no_irq_at_10: assert property (management_interrupt_pin_n && port_stat[0].speed == SPD_10
    && port_stat[1].speed == SPD_10 && $past(port_stat[0].speed) == SPD_10 && $past(port_stat[1].speed) == SPD_10
    |=> management_interrupt_pin_n) else $error("interrupt at 10");
endmodule // led_fail_ind_sva

bind led_fail_ind led_fail_ind_sva chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_stat(port_stat),
  .low_power_hold(low_power_hold), .led_n(led_n), .serial_led_bits(serial_led_bits),
  .link_drop_alert_pin(link_drop_alert_pin), .management_interrupt_pin_n(management_interrupt_pin_n));

// ===== tb/port_core_model.sv
/*
  Behavioural port core feeding link state to the indicator.
  Assumes the bench sets link, speed, integrity and activity requests.
*/
`timescale 1ns/1ps
module port_core_model
  import led_fail_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests
  input wire logic [NPORT-1:0] up_req,
  input wire logic [NPORT-1:0] bad_req,
  input wire logic [3:0] spd_req,
  input wire logic act_req,
  // Status out
  output port_stat_t [NPORT-1:0] stat
);
  // No low-power idle is modelled, so the drop pin stays meaningful
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        stat[p].link_up <= up_req[p];
        stat[p].speed <= spd_req[2*p +: 2];
        stat[p].integrity_fail <= bad_req[p];
        stat[p].activity <= act_req;
        stat[p].full_duplex <= 1'($urandom);
        stat[p].collision <= 1'($urandom);
        stat[p].an_fault <= 1'b0;
      end
    end
  end
endmodule // port_core_model

// ===== tb/led_fail_ind_bench.sv
/*
  Self-checking bench for led_fail_ind with shortened timers.
  Assumes tick 20, dimming period 10 with 2 on; APB answers queued.
*/
`timescale 1ns/1ps
module led_fail_ind_bench
  import led_fail_pkg::*;
;
  localparam int TICK = 20;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, low_power_hold = 0, act_req = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, management_interrupt_pin_n;
  port_stat_t [NPORT-1:0] port_stat;
  logic [NLED-1:0] led_n, serial_led_bits;
  logic [NPORT-1:0] link_drop_alert_pin, up_req = 2'h0, bad_req = 2'h0;
  logic [3:0] spd_req = 4'h5;
  logic [33:0] exp_q[$], mon_e;
  int failures = 0, total_checks = 0, c;

  always #2.5 clk = ~clk;

  led_fail_ind #(.TICK_CYC(TICK), .PWM_CYC(10), .PWM_ON_CYC(2)) dut_u (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_stat(port_stat), .low_power_hold(low_power_hold), .led_n(led_n),
    .serial_led_bits(serial_led_bits), .link_drop_alert_pin(link_drop_alert_pin),
    .management_interrupt_pin_n(management_interrupt_pin_n));
  port_core_model core_u (.clk(clk), .rst(rst), .up_req(up_req), .bad_req(bad_req), .spd_req(spd_req),
    .act_req(act_req), .stat(port_stat));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] ed,
                     input logic ee);
    int n;
    n = 0;
    exp_q.push_back({w, ee, ed});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed);
    apb(1'b0, a, 32'h0, ed, 1'b0);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Skip the output latency, then time the second toggle interval
  task automatic half(input int i, output int cnt);
    logic v;
    repeat (8) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      v = led_n[i];
      cnt = 0;
      while (led_n[i] === v && cnt < 1000) begin
        @(posedge clk);
        cnt++;
      end
    end
  endtask

  task automatic lows(output int cnt);
    cnt = 0;
    repeat (10) begin
      @(posedge clk);
      if (led_n[0] === 1'b0) cnt++;
    end
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      chk("pslverr", 32'(mon_e[32]), 32'(pslverr));
      if (!mon_e[33]) chk("prdata", mon_e[31:0], prdata);
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(32'hF909));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    chk("led_n", 32'hF, 32'(led_n));
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h0);
    apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
    r = $urandom & 32'h3FFFF;
    wr(8'h04, r);
    rd(8'h04, r);
    wr(8'h08, 32'h300EE);
    wr(8'h04, 32'hEF);
    wt(4);
    chk("led_n", 32'hE, 32'(led_n));
    wr(8'h00, 32'h1);
    wt(4);
    chk("led_n", 32'hB, 32'(led_n));
    chk("serial", 32'h1, 32'(serial_led_bits));
    wr(8'h00, 32'h2);
    wt(4);
    lows(c);
    chk("dim_on", 32'd2, 32'(c));
    wr(8'h04, 32'h1E5);
    wt(4);
    lows(c);
    chk("x_on", 32'd10, 32'(c));
    wr(8'h04, 32'h1E4);
    wt(4);
    chk("x_off", 32'h1, 32'(led_n[0]));
    wr(8'h00, 32'h0);
    up_req <= 2'b01;
    act_req <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, (32'(k) << 16) | 32'hEA);
      half(0, c);
      chk("blink", 32'((8 >> k) * TICK), 32'(c));
    end
    // Steady activity: every stretched level lasts exactly one stretch period
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, (32'(k) << 16) | 32'h40EA);
      half(0, c);
      chk("stretch", 32'((2 << k) * TICK), 32'(c));
    end
    wr(8'h04, 32'h10E2);
    half(0, c);
    chk("combine", 32'(8 * TICK), 32'(c));
    wr(8'h04, 32'hE2);
    wt(4);
    chk("primary", 32'h0, 32'(led_n[0]));
    wt(8 * TICK);
    chk("primary", 32'h0, 32'(led_n[0]));
    act_req <= 1'b0;
    wr(8'h04, 32'h1E6);
    wt(4);
    chk("x_drop", 32'h1, 32'(led_n[0]));
    up_req <= 2'b00;
    wt(6);
    chk("alert0", 32'h0, 32'(link_drop_alert_pin[0]));
    chk("irq", 32'h0, 32'(management_interrupt_pin_n));
    chk("x_drop", 32'h0, 32'(led_n[0]));
    rd(8'h0C, 32'h80);
    wt(1);
    chk("irq", 32'h0, 32'(management_interrupt_pin_n));
    wr(8'h0C, 32'h80);
    wt(2);
    chk("irq", 32'h1, 32'(management_interrupt_pin_n));
    spd_req <= 4'h0;
    up_req <= 2'b01;
    wt(4);
    up_req <= 2'b00;
    wt(6);
    chk("alert0", 32'h0, 32'(link_drop_alert_pin[0]));
    chk("irq", 32'h1, 32'(management_interrupt_pin_n));
    rd(8'h0C, 32'h0);
    spd_req <= 4'h8;
    up_req <= 2'b10;
    wt(4);
    chk("alert1", 32'h1, 32'(link_drop_alert_pin[1]));
    bad_req <= 2'b10;
    wt(6);
    chk("alert1", 32'h0, 32'(link_drop_alert_pin[1]));
    chk("irq", 32'h0, 32'(management_interrupt_pin_n));
    rd(8'h10, 32'h84);
    wr(8'h10, 32'h80);
    bad_req <= 2'b00;
    wr(8'h04, 32'h0E);
    wr(8'h00, 32'h4);
    low_power_hold <= 1'b1;
    wt(4);
    low_power_hold <= 1'b0;
    half(1, c);
    chk("after_rst", 32'(8 * TICK), 32'(c));
    chk("forced", 32'h1, 32'(led_n[0]));
    // Half a blink period later the phase is inverted
    wt(8 * TICK);
    chk("forced", 32'h1, 32'(led_n[0]));
    wt(900);
    chk("after_rst", 32'h1, 32'(led_n[1]));
    wr(8'h00, 32'hC);
    half(1, c);
    chk("soft_rst", 32'(8 * TICK), 32'(c));
    tally_and_finish;
  end
endmodule // led_fail_ind_bench
